// file: common/pin_bank_defs.svh
`ifndef PIN_BANK_DEFS_SVH
`define PIN_BANK_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PIN0_CFG_IDX 8'h1d
`define PIN12_CFG_IDX 8'h1e
`define PIN3_CFG_IDX 8'h1f
`define PIN_STATE_IDX 8'h30

// ----------------------------------------------------------------------------
// Field positions inside one pin nibble and inside the registers
// ----------------------------------------------------------------------------
`define FLD_EN 0
`define FLD_DIR 1
`define FLD_REMOTE 2
`define FLD_LEVEL 3
`define PIN2_NIBBLE_LSB 4
`define REV_LSB 4
`define STATE_STRAP_BIT 4

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define CFG_RESET_NIBBLE 4'h0
`define CFG_STRAP_NIBBLE 4'h3
`define STRAP_SETTLE_CYC 2'h3

`endif

// file: common/pin_bank_pkg.sv
`default_nettype none

package pin_bank_pkg;

   // Pad role, encoded as {direction, enable}.
   typedef enum logic [1:0] {
      ROLE_FUNC_OUT = 2'b00,
      ROLE_GPIO_OUT = 2'b01,
      ROLE_TRISTATE = 2'b10,
      ROLE_GPIO_IN = 2'b11
   } pad_role_t;

   typedef enum logic {
      BOOT_SETTLE,
      BOOT_RUN
   } boot_state_t;

endpackage : pin_bank_pkg

`default_nettype wire

// file: rtl/pin_pad_ctl.sv
`include "pin_bank_defs.svh"
`default_nettype none

module pin_pad_ctl (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Configuration of this pin
   input wire logic alt_sel_i,
   input wire logic [3:0] cfg_i,
   input wire logic remote_val_i,
   input wire logic func_val_i,
   // Primary pad
   input wire logic pri_in_i,
   output logic pri_out_o,
   output logic pri_oe_o,
   // Alternate pad
   input wire logic alt_in_i,
   output logic alt_out_o,
   output logic alt_oe_o,
   // Sampled level
   output logic sampled_o
);

   logic out_r, out_nxt, oe_r, oe_nxt;
   logic [2:0] sync_r, sync_nxt;
   logic sampled_r, sampled_nxt;
   pin_bank_pkg::pad_role_t role;

   // ----------------------------------------------------------------------------
   // Pad drive
   // ----------------------------------------------------------------------------
   always_comb begin
      role = pin_bank_pkg::pad_role_t'({cfg_i[`FLD_DIR], cfg_i[`FLD_EN]});
      out_nxt = 1'b0;
      oe_nxt = 1'b0;
      unique case (role)
         pin_bank_pkg::ROLE_FUNC_OUT: begin
            oe_nxt = 1'b1;
            out_nxt = func_val_i;
         end
         pin_bank_pkg::ROLE_TRISTATE: begin
            oe_nxt = 1'b0;
         end
         pin_bank_pkg::ROLE_GPIO_OUT: begin
            oe_nxt = 1'b1;
            out_nxt = cfg_i[`FLD_LEVEL];
         end
         pin_bank_pkg::ROLE_GPIO_IN: begin
            oe_nxt = 1'b0;
         end
      endcase
      // Remote control takes a pin in either GPIO role and makes it an output.
      if (cfg_i[`FLD_EN] && cfg_i[`FLD_REMOTE]) begin
         oe_nxt = 1'b1;
         out_nxt = remote_val_i;
      end
   end

   // ----------------------------------------------------------------------------
   // Input sampling
   // ----------------------------------------------------------------------------
   always_comb begin
      // The strap is latched once, so the mux ahead of the first flop is static.
      sync_nxt = {sync_r[1:0], alt_sel_i ? alt_in_i : pri_in_i};
      sampled_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : sampled_r;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_r <= 1'b0;
         oe_r <= 1'b0;
         sync_r <= 3'h0;
         sampled_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
         oe_r <= oe_nxt;
         sync_r <= sync_nxt;
         sampled_r <= sampled_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // Port steering
   // ----------------------------------------------------------------------------
   assign pri_out_o = alt_sel_i ? 1'b0 : out_r;
   assign pri_oe_o = alt_sel_i ? 1'b0 : oe_r;
   assign alt_out_o = alt_sel_i ? out_r : 1'b0;
   assign alt_oe_o = alt_sel_i ? oe_r : 1'b0;
   assign sampled_o = sampled_r;

endmodule : pin_pad_ctl

`default_nettype wire

// file: rtl/deser_pin_config_bank.sv
// Contract
// - Strap set: each config register steers the alternate pin of same number.
// - Stored level drives the pin only in GPIO output with remote off.
// - Remote bit set makes the pin an output carrying the remote value; the code does this only when enable is 1 (either GPIO role).
// - {direction, enable}: 00 functional out, 10 tri-state, 01 GPIO out, 11 in.
// - Direction and enable reset to 0, or to 1 when the strap is 1.
// - Lower slot: enable bit 0 and direction bit 1 form the role code.
// - Pin two: enable bit 4 and direction bit 5 form its role code.
// - Pin-0 register bits 7-4 are a read-only revision code; writes ignored.
//
// Implementation choice: the Wishbone slave port.
`include "pin_bank_defs.svh"
`default_nettype none

module deser_pin_config_bank #(
   // Value is arbitrary.
   parameter logic [3:0] REVISION_CODE = 4'h5
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Strap pin
   input wire logic second_port_strap_i,
   // Link side
   input wire logic [3:0] remote_val_i,
   input wire logic [3:0] func_val_i,
   output logic [3:0] fwd_level_o,
   output logic [3:0] fwd_valid_o,
   // Primary pins
   input wire logic [3:0] pri_pin_in_i,
   output logic [3:0] pri_pin_out_o,
   output logic [3:0] pri_pin_oe_o,
   // Alternate pins
   input wire logic [3:0] alt_pin_in_i,
   output logic [3:0] alt_pin_out_o,
   output logic [3:0] alt_pin_oe_o
);

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   // Returns the nibble {level, remote, direction, enable} of one pin.
   function automatic logic [3:0] pin_cfg(input logic [3:0] c0, input logic [7:0] c12,
                                          input logic [3:0] c3, input int idx);
      logic [3:0] r;
      r = c0;
      unique case (idx)
         0: r = c0;
         1: r = c12[3:0];
         2: r = c12[7:`PIN2_NIBBLE_LSB];
         default: r = c3;
      endcase
      return r;
   endfunction : pin_cfg

   function automatic logic in_role(input logic [3:0] c);
      return c[`FLD_DIR] & c[`FLD_EN] & ~c[`FLD_REMOTE];
   endfunction : in_role

   // ----------------------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------------------
   logic [2:0] strap_sync_r, strap_sync_nxt;
   logic strap_r, strap_nxt;
   logic port_sel_r, port_sel_nxt;
   logic [1:0] boot_cnt_r, boot_cnt_nxt;
   pin_bank_pkg::boot_state_t boot_st_r, boot_st_nxt;
   logic boot_load;

   always_comb begin
      strap_sync_nxt = {strap_sync_r[1:0], second_port_strap_i};
      strap_nxt = (strap_sync_r[1] == strap_sync_r[2]) ? strap_sync_r[2] : strap_r;
      boot_st_nxt = boot_st_r;
      boot_cnt_nxt = boot_cnt_r;
      port_sel_nxt = port_sel_r;
      boot_load = 1'b0;
      unique case (boot_st_r)
         pin_bank_pkg::BOOT_SETTLE: begin
            // Wait until the synchroniser has seen the settled strap level.
            if (boot_cnt_r == `STRAP_SETTLE_CYC) begin
               boot_st_nxt = pin_bank_pkg::BOOT_RUN;
               // The flops only agree on this edge, so the held strap would still be stale.
               port_sel_nxt = strap_nxt;
               boot_load = 1'b1;
            end else begin
               boot_cnt_nxt = boot_cnt_r + 2'h1;
            end
         end
         pin_bank_pkg::BOOT_RUN: begin
            boot_load = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_sync_r <= 3'h0;
         strap_r <= 1'b0;
         port_sel_r <= 1'b0;
         boot_cnt_r <= 2'h0;
         boot_st_r <= pin_bank_pkg::BOOT_SETTLE;
      end else begin
         strap_sync_r <= strap_sync_nxt;
         strap_r <= strap_nxt;
         port_sel_r <= port_sel_nxt;
         boot_cnt_r <= boot_cnt_nxt;
         boot_st_r <= boot_st_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // Register file and bus slave
   // ----------------------------------------------------------------------------
   logic [3:0] cfg0_r, cfg0_nxt;
   logic [7:0] cfg12_r, cfg12_nxt;
   logic [3:0] cfg3_r, cfg3_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic [3:0] sampled;
   logic [7:0] idx;
   logic req, wr;
   logic [3:0] boot_nib;

   always_comb begin
      idx = wb_adr_i[9:2];
      // Requests wait for the strap to be latched, so boot values cannot clobber writes.
      req = wb_cyc_i & wb_stb_i & ~ack_r & (boot_st_r == pin_bank_pkg::BOOT_RUN);
      wr = req & wb_we_i & wb_sel_i[0];
      ack_nxt = req;
      dat_nxt = dat_r;
      cfg0_nxt = cfg0_r;
      cfg12_nxt = cfg12_r;
      cfg3_nxt = cfg3_r;
      boot_nib = strap_nxt ? `CFG_STRAP_NIBBLE : `CFG_RESET_NIBBLE;
      if (boot_load) begin
         cfg0_nxt = boot_nib;
         cfg12_nxt = {boot_nib, boot_nib};
         cfg3_nxt = boot_nib;
      end
      if (wr) begin
         unique case (idx)
            `PIN0_CFG_IDX: cfg0_nxt = wb_dat_i[3:0];
            `PIN12_CFG_IDX: cfg12_nxt = wb_dat_i[7:0];
            `PIN3_CFG_IDX: cfg3_nxt = wb_dat_i[3:0];
            default: cfg0_nxt = cfg0_nxt;
         endcase
      end
      if (req) begin
         unique case (idx)
            `PIN0_CFG_IDX: dat_nxt = {24'h0, REVISION_CODE, cfg0_r};
            `PIN12_CFG_IDX: dat_nxt = {24'h0, cfg12_r};
            `PIN3_CFG_IDX: dat_nxt = {28'h0, cfg3_r};
            `PIN_STATE_IDX: dat_nxt = {27'h0, port_sel_r, sampled};
            default: dat_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg0_r <= `CFG_RESET_NIBBLE;
         cfg12_r <= {`CFG_RESET_NIBBLE, `CFG_RESET_NIBBLE};
         cfg3_r <= `CFG_RESET_NIBBLE;
         ack_r <= 1'b0;
         dat_r <= 32'h0;
      end else begin
         cfg0_r <= cfg0_nxt;
         cfg12_r <= cfg12_nxt;
         cfg3_r <= cfg3_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // ----------------------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------------------
   for (genvar g = 0; g < 4; g++) begin : g_pin
      logic [3:0] cfg;
      assign cfg = pin_cfg(cfg0_r, cfg12_r, cfg3_r, g);

      pin_pad_ctl u_pad (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .alt_sel_i(port_sel_r),
         .cfg_i(cfg),
         .remote_val_i(remote_val_i[g]),
         .func_val_i(func_val_i[g]),
         .pri_in_i(pri_pin_in_i[g]),
         .pri_out_o(pri_pin_out_o[g]),
         .pri_oe_o(pri_pin_oe_o[g]),
         .alt_in_i(alt_pin_in_i[g]),
         .alt_out_o(alt_pin_out_o[g]),
         .alt_oe_o(alt_pin_oe_o[g]),
         .sampled_o(sampled[g])
      );

      // Forwarding is flagged only while the pin really is a local input.
      assign fwd_valid_o[g] = in_role(cfg);
   end

   assign fwd_level_o = sampled;

endmodule : deser_pin_config_bank

`default_nettype wire

// file: testbench/remote_ser_model.sv
`default_nettype none
module remote_ser_model (
   // Clock
   input wire logic clk_i,
   // Pin values wanted by the far side
   input wire logic [3:0] want_i,
   output logic [3:0] remote_val_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // The link delivers each value one clock late, so nothing may rely on a same-cycle copy.
   always_ff @(posedge clk_i) begin
      remote_val_o <= want_i;
   end
endmodule : remote_ser_model
`default_nettype wire

// file: testbench/deser_pin_config_bank_assertions.sv
`default_nettype none
module deser_pin_config_bank_assertions #(
   parameter logic [3:0] REVISION_CODE = 4'h5
) (
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pins
   input wire logic [3:0] fwd_valid_o,
   input wire logic [3:0] pri_pin_oe_o,
   input wire logic [3:0] alt_pin_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_next;
      $rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_hi_zero;
      wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper read bits not zero");
   property p_rev;
      wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h1d |-> wb_dat_o[7:4] == REVISION_CODE;
   endproperty
   a_rev: assert property (p_rev) else $error("revision field wrong");
   property p_unmapped;
      wb_ack_o && !wb_we_i && !(wb_adr_i[9:2] inside {8'h1d, 8'h1e, 8'h1f, 8'h30})
         |-> wb_dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_port_excl;
      (pri_pin_oe_o & alt_pin_oe_o) == 4'h0;
   endproperty
   a_port_excl: assert property (p_port_excl) else $error("both pin sets driven");
   property p_input_hiz;
      (fwd_valid_o & $past(fwd_valid_o) & (pri_pin_oe_o | alt_pin_oe_o)) == 4'h0;
   endproperty
   a_input_hiz: assert property (p_input_hiz) else $error("input pin driven");
endmodule : deser_pin_config_bank_assertions
bind deser_pin_config_bank deser_pin_config_bank_assertions #(
   .REVISION_CODE(REVISION_CODE)
) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
   .fwd_valid_o, .pri_pin_oe_o, .alt_pin_oe_o);
`default_nettype wire

// file: testbench/deser_pin_config_bank_tb.sv
`include "pin_bank_defs.svh"
`default_nettype none
module deser_pin_config_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] REV = 4'h5;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sp = 0, pad_chk = 0, ack;
   logic [9:0] adr = '0;
   logic [31:0] wdat = '0, rdat, got, ex;
   logic [3:0] want = '0, func = '0, pin_in = '0, alt_in = '0;
   logic [3:0] rval, lvl, valid, po, pout, ao, aout;
   logic [3:0] n[4];
   logic [1:0] pd;
   logic [23:0] e;
   logic [7:0] rnd = 8'h22;
   logic [31:0] expq[$];
   int err_count = 0, n_checks = 0;
   deser_pin_config_bank #(.REVISION_CODE(REV)) u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .second_port_strap_i(sp), .remote_val_i(rval),
      .func_val_i(func), .fwd_level_o(lvl), .fwd_valid_o(valid), .pri_pin_in_i(pin_in),
      .pri_pin_out_o(pout), .pri_pin_oe_o(po), .alt_pin_in_i(alt_in),
      .alt_pin_out_o(aout), .alt_pin_oe_o(ao));
   remote_ser_model u_remote (.clk_i, .want_i(want), .remote_val_o(rval));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // Returns {drive enable, level} of one pin from its nibble.
   function automatic logic [1:0] pad(input logic [3:0] c, input logic f, input logic r);
      if (c[0] && c[2]) return {1'b1, r};
      if (c[1:0] == 2'b00) return {1'b1, f};
      if (c[1:0] == 2'b01) return {1'b1, c[3]};
      return 2'b00;
   endfunction : pad
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   // A read pushes its expected data; a write only updates the register.
   task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int i;
      if (!w) expq.push_back(d);
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= d;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack !== 1'b1 && i < 20);
      cyc <= 0;
      stb <= 0;
      if (ack !== 1'b1) begin
         err_count++;
         tally_and_finish();
      end
   endtask : wb
   task automatic pads(input logic [23:0] x);
      expq.push_back({8'h0, x});
      @(posedge clk_i);
      pad_chk <= 1;
      @(posedge clk_i);
      pad_chk <= 0;
   endtask : pads
   always @(posedge clk_i) begin
      if ((ack === 1'b1 && we === 1'b0) || pad_chk) begin
         got = pad_chk ? {8'h0, valid, lvl & valid, po, pout & po, ao, aout & ao} : rdat;
         ex = expq.pop_front();
         n_checks++;
         if (got !== ex) begin
            $display("BAD t=%0t exp=%h got=%h", $time, ex, got);
            err_count++;
         end
      end
   end
   // --------------------------------------------------------------
   // Main sequence, once per strap setting
   // --------------------------------------------------------------
   initial begin
      for (int s = 0; s < 2; s++) begin
         sp <= s[0];
         rst_i <= 1;
         repeat (12) @(posedge clk_i);
         rst_i <= 0;
         repeat (10) @(posedge clk_i);
         wb(0, `PIN0_CFG_IDX, {24'h0, REV, 2'b00, sp, sp});
         wb(0, `PIN12_CFG_IDX, {24'h0, 2'b00, sp, sp, 2'b00, sp, sp});
         wb(0, `PIN3_CFG_IDX, {28'h0, 2'b00, sp, sp});
         wb(0, 8'h3c, 32'h0);
         for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 4; i++) begin
               rnd = lfsr(rnd);
               n[i] = {rnd[0], k[2], 2'(k + i)};
            end
            rnd = lfsr(rnd);
            func <= rnd[3:0];
            want <= rnd[7:4];
            rnd = lfsr(rnd);
            pin_in <= rnd[3:0];
            alt_in <= rnd[7:4];
            wb(1, `PIN0_CFG_IDX, {24'h0, rnd[7:4], n[0]});
            wb(1, `PIN12_CFG_IDX, {24'h0, n[2], n[1]});
            wb(1, `PIN3_CFG_IDX, {24'h0, rnd[3:0], n[3]});
            wb(0, `PIN0_CFG_IDX, {24'h0, REV, n[0]});
            wb(0, `PIN12_CFG_IDX, {24'h0, n[2], n[1]});
            wb(0, `PIN3_CFG_IDX, {28'h0, n[3]});
            repeat (6) @(posedge clk_i);
            for (int i = 0; i < 4; i++) begin
               pd = pad(n[i], func[i], want[i]);
               e[20+i] = n[i][1:0] == 2'b11 && !n[i][2];
               e[16+i] = e[20+i] & (sp ? alt_in[i] : pin_in[i]);
               e[12+i] = !sp & pd[1];
               e[8+i] = !sp & pd[1] & pd[0];
               e[4+i] = sp & pd[1];
               e[i] = sp & pd[1] & pd[0];
            end
            pads(e);
         end
         $display("strap %0d done, checks %0d", s, n_checks);
      end
      tally_and_finish();
   end
endmodule : deser_pin_config_bank_tb
`default_nettype wire
